// ### logic/ocadc_regs.vh
`ifndef OCADC_REGS_VH
`define OCADC_REGS_VH

// Register indices; byte address is four times the index
`define OCADC_IDX_PROX_GAIN    6'h0b
`define OCADC_IDX_PROX_MISC    6'h0c
`define OCADC_IDX_AMB_IR_SEL   6'h0e
`define OCADC_IDX_AUX_SEL      6'h0f
`define OCADC_IDX_VIS_REC      6'h10
`define OCADC_IDX_VIS_GAIN     6'h11
`define OCADC_IDX_CONTROL      6'h20
`define OCADC_IDX_STATUS       6'h21
`define OCADC_IDX_RESULT       6'h22

// Reset values
`define OCADC_RST_PROX_GAIN    8'h00
`define OCADC_RST_PROX_MISC    8'h04
`define OCADC_RST_AMB_IR_SEL   8'h00
`define OCADC_RST_AUX_SEL      8'h65
`define OCADC_RST_VIS_REC      8'h70
`define OCADC_RST_VIS_GAIN     8'h00

// Writable bit masks; other bits read as zero
`define OCADC_MSK_GAIN         8'h07
`define OCADC_MSK_PROX_MISC    8'h24
`define OCADC_MSK_VIS_REC      8'h70

// Field positions
`define OCADC_GAIN_MSB         2
`define OCADC_RANGE_BIT        5
`define OCADC_MODE_BIT         2
`define OCADC_REC_MSB          6
`define OCADC_REC_LSB          4
`define OCADC_CTL_START_BIT    0
`define OCADC_CTL_CHAN_MSB     2
`define OCADC_CTL_CHAN_LSB     1
`define OCADC_CTL_EARLY_BIT    3
`define OCADC_STA_BUSY_BIT     0
`define OCADC_STA_DONE_BIT     1

// Channel codes
`define OCADC_CHAN_PROX        2'h0
`define OCADC_CHAN_VIS         2'h1
`define OCADC_CHAN_AMB_IR      2'h2
`define OCADC_CHAN_AUX         2'h3

// Converter input selections
`define OCADC_SEL_SMALL_IR     8'h00
`define OCADC_SEL_LARGE_IR     8'h03
`define OCADC_SEL_VISIBLE      8'h02
`define OCADC_SEL_TEMP         8'h65
`define OCADC_SEL_VDD          8'h75

// Timing
`define OCADC_ADC_CLK_NS       50
`define OCADC_SYS_CLK_MHZ      100
`define OCADC_ADC_CLK_CYC      ((`OCADC_ADC_CLK_NS * `OCADC_SYS_CLK_MHZ + 999) / 1000)
`define OCADC_INTEG_CLKS       16
`define OCADC_EMIT_CLKS        8

// Visible recovery lengths in divided converter clocks, one per code
`define OCADC_REC_CLKS_0       9'h001
`define OCADC_REC_CLKS_1       9'h007
`define OCADC_REC_CLKS_2       9'h00f
`define OCADC_REC_CLKS_3       9'h01f
`define OCADC_REC_CLKS_4       9'h03f
`define OCADC_REC_CLKS_5       9'h07f
`define OCADC_REC_CLKS_6       9'h0ff
`define OCADC_REC_CLKS_7       9'h1ff

`endif

// ### logic/ocadc_clk_div.v
`timescale 1ns/100ps
// Converter clock generator: a base prescaler makes the converter clock,
// a second stage divides it by two raised to the gain exponent.
module ocadc_clk_div #(
  parameter BASE_CYC = 5,
  parameter PRE_W    = 4
) (
  input  wire       clk_sys,   // System clock
  input  wire       rst,       // Async reset, active high
  input  wire       ce,        // Clock enable
  input  wire       restart,   // Realign both stages
  input  wire [2:0] gain_exp,  // Divide exponent
  output wire       tick       // One pulse per divided converter clock
);
  localparam [PRE_W-1:0] PRE_LAST = BASE_CYC[PRE_W-1:0] - {{(PRE_W-1){1'b0}}, 1'b1};

  reg  [PRE_W-1:0] pre_reg;
  reg  [6:0]       div_reg;
  wire             adc_clk_pulse;
  wire [6:0]       div_last;

  assign adc_clk_pulse = (pre_reg == PRE_LAST);
  assign div_last      = (7'h01 << gain_exp) - 7'h01;
  assign tick          = adc_clk_pulse & (div_reg == div_last) & ~restart;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_reg <= {PRE_W{1'b0}};
      div_reg <= 7'h00;
    end else if (ce) begin
      if (restart) begin
        pre_reg <= {PRE_W{1'b0}};
        div_reg <= 7'h00;
      end else if (adc_clk_pulse) begin
        pre_reg <= {PRE_W{1'b0}};
        div_reg <= (div_reg == div_last) ? 7'h00 : div_reg + 7'h01;
      end else begin
        pre_reg <= pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // ocadc_clk_div

// ### logic/ocadc_channel.v
// Register access over Wishbone is this design's own decision.
`timescale 1ns/100ps
`include "ocadc_regs.vh"
module ocadc_channel #(
  parameter DATA_W      = 16,
  parameter INTEG_CLKS  = `OCADC_INTEG_CLKS,
  parameter EMIT_CLKS   = `OCADC_EMIT_CLKS,
  parameter PROX_INPUT  = `OCADC_SEL_LARGE_IR
) (
  input  wire              clk_sys,        // System clock, 100 MHz
  input  wire              rst,            // Async reset, active high
  input  wire              ce,             // Clock enable, freezes all state when low
  input  wire              wb_cyc_i,       // Wishbone cycle
  input  wire              wb_stb_i,       // Wishbone strobe
  input  wire              wb_we_i,        // Wishbone write enable
  input  wire [7:0]        wb_adr_i,       // Wishbone byte address
  input  wire [3:0]        wb_sel_i,       // Wishbone byte selects
  input  wire [31:0]       wb_dat_i,       // Wishbone write data
  output reg  [31:0]       wb_dat_o,       // Wishbone read data
  output wire              wb_ack_o,       // Wishbone acknowledge
  input  wire [DATA_W-1:0] adc_data_in,    // Converter sample from the analog side
  output reg  [7:0]        adc_input_sel,  // Converter input selection
  output reg               adc_ref_gnd,    // Measurement referenced to ground
  output reg               adc_high_range, // Gain divided for high signal range
  output reg               adc_raw_mode,   // Raw converter measurement, no reference
  output reg               conv_active,    // Integration in progress
  output reg               infrared_emitter, // Emitter drive
  output reg               conv_done       // One-cycle pulse at result capture
);
  localparam ST_IDLE  = 2'b00;
  localparam ST_REC   = 2'b01;
  localparam ST_INTEG = 2'b10;

  reg  [7:0]        prox_gain_reg;
  reg  [7:0]        prox_misc_reg;
  reg  [7:0]        amb_ir_sel_reg;
  reg  [7:0]        aux_sel_reg;
  reg  [7:0]        vis_rec_reg;
  reg  [7:0]        vis_gain_reg;
  reg  [1:0]        chan_reg;
  reg               early_reg;
  reg               done_reg;
  reg  [DATA_W-1:0] result_reg;
  reg               ack_reg;

  reg  [1:0]        state_reg;
  reg  [1:0]        run_chan_reg;
  reg  [2:0]        run_exp_reg;
  reg               run_normal_reg;
  reg  [8:0]        count_reg;

  reg  [DATA_W-1:0] sync1_reg;
  reg  [DATA_W-1:0] sync2_reg;
  reg  [DATA_W-1:0] sync3_reg;
  reg  [DATA_W-1:0] stable_reg;

  wire              req;
  wire              wr_en;
  wire [5:0]        idx;
  wire              start;
  wire [1:0]        start_chan;
  wire              start_early;
  wire              use_vis_rec;
  reg  [2:0]        start_exp;
  reg  [8:0]        start_rec;
  reg  [7:0]        start_sel;
  wire              tick;
  wire              restart;
  wire              last_tick;
  wire              done_clear;
  reg  [31:0]       rd_next;

  assign req        = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_en      = req & wb_we_i & wb_sel_i[0];
  assign idx        = wb_adr_i[7:2];
  assign wb_ack_o   = ack_reg;
  assign start      = wr_en & (idx == `OCADC_IDX_CONTROL)
                      & wb_dat_i[`OCADC_CTL_START_BIT] & (state_reg == ST_IDLE);
  assign start_chan  = wb_dat_i[`OCADC_CTL_CHAN_MSB:`OCADC_CTL_CHAN_LSB];
  assign start_early = wb_dat_i[`OCADC_CTL_EARLY_BIT];
  assign done_clear  = wr_en & (idx == `OCADC_IDX_STATUS) & wb_dat_i[`OCADC_STA_DONE_BIT];

  // Early silicon shares the visible recovery and gain with ambient infrared; the flag
  // written with the start word counts, not the one left over from the previous start
  assign use_vis_rec = (start_chan == `OCADC_CHAN_VIS)
                       | ((start_chan == `OCADC_CHAN_AMB_IR) & start_early);
  assign restart     = start;
  assign last_tick   = tick & (count_reg == 9'h001);

  always @* begin
    case (start_chan)
      `OCADC_CHAN_PROX:   start_exp = prox_gain_reg[`OCADC_GAIN_MSB:0];
      `OCADC_CHAN_VIS:    start_exp = vis_gain_reg[`OCADC_GAIN_MSB:0];
      `OCADC_CHAN_AMB_IR: start_exp = start_early ? vis_gain_reg[`OCADC_GAIN_MSB:0] : 3'h0;
      default:            start_exp = 3'h0;
    endcase
  end

  // Only visible runs, or ambient infrared on early silicon, wait before integrating
  always @* begin
    start_rec = 9'h000;
    if (use_vis_rec) begin
      case (vis_rec_reg[`OCADC_REC_MSB:`OCADC_REC_LSB])
        3'h0:    start_rec = `OCADC_REC_CLKS_0;
        3'h1:    start_rec = `OCADC_REC_CLKS_1;
        3'h2:    start_rec = `OCADC_REC_CLKS_2;
        3'h3:    start_rec = `OCADC_REC_CLKS_3;
        3'h4:    start_rec = `OCADC_REC_CLKS_4;
        3'h5:    start_rec = `OCADC_REC_CLKS_5;
        3'h6:    start_rec = `OCADC_REC_CLKS_6;
        default: start_rec = `OCADC_REC_CLKS_7;
      endcase
    end
  end

  always @* begin
    case (start_chan)
      `OCADC_CHAN_PROX:   start_sel = PROX_INPUT;
      `OCADC_CHAN_VIS:    start_sel = `OCADC_SEL_VISIBLE;
      `OCADC_CHAN_AMB_IR: start_sel = amb_ir_sel_reg;
      default:            start_sel = aux_sel_reg;
    endcase
  end

  ocadc_clk_div #(
    .BASE_CYC (`OCADC_ADC_CLK_CYC),
    .PRE_W    (4)
  ) u_clk_div (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .restart  (restart),
    .gain_exp (run_exp_reg),
    .tick     (tick)
  );

  // Sample pins come from the analog domain; a word may be caught mid-change, so only
  // a value seen on two edges in a row is passed on
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_reg  <= {DATA_W{1'b0}};
      sync2_reg  <= {DATA_W{1'b0}};
      sync3_reg  <= {DATA_W{1'b0}};
      stable_reg <= {DATA_W{1'b0}};
    end else if (ce) begin
      sync1_reg <= adc_data_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync3_reg == sync2_reg) begin
        stable_reg <= sync3_reg;
      end
    end
  end

  always @* begin
    rd_next = 32'h0000_0000;
    case (idx)
      `OCADC_IDX_PROX_GAIN:  rd_next[7:0] = prox_gain_reg;
      `OCADC_IDX_PROX_MISC:  rd_next[7:0] = prox_misc_reg;
      `OCADC_IDX_AMB_IR_SEL: rd_next[7:0] = amb_ir_sel_reg;
      `OCADC_IDX_AUX_SEL:    rd_next[7:0] = aux_sel_reg;
      `OCADC_IDX_VIS_REC:    rd_next[7:0] = vis_rec_reg;
      `OCADC_IDX_VIS_GAIN:   rd_next[7:0] = vis_gain_reg;
      `OCADC_IDX_CONTROL:    rd_next[3:0] = {early_reg, chan_reg, 1'b0};
      `OCADC_IDX_STATUS:     rd_next[3:0] = {run_chan_reg, done_reg, (state_reg != ST_IDLE)};
      `OCADC_IDX_RESULT:     rd_next[DATA_W-1:0] = result_reg;
      default:               rd_next = 32'h0000_0000;
    endcase
  end

  // Register file; one-cycle ack, unmapped reads return zero
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_reg        <= 1'b0;
      wb_dat_o       <= 32'h0000_0000;
      prox_gain_reg  <= `OCADC_RST_PROX_GAIN;
      prox_misc_reg  <= `OCADC_RST_PROX_MISC;
      amb_ir_sel_reg <= `OCADC_RST_AMB_IR_SEL;
      aux_sel_reg    <= `OCADC_RST_AUX_SEL;
      vis_rec_reg    <= `OCADC_RST_VIS_REC;
      vis_gain_reg   <= `OCADC_RST_VIS_GAIN;
      chan_reg       <= `OCADC_CHAN_PROX;
      early_reg      <= 1'b0;
    end else if (ce) begin
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
      if (req) begin
        wb_dat_o <= rd_next;
      end
      // No protection against gain above five; software owns that limit
      if (wr_en) begin
        case (idx)
          `OCADC_IDX_PROX_GAIN:  prox_gain_reg  <= wb_dat_i[7:0] & `OCADC_MSK_GAIN;
          `OCADC_IDX_PROX_MISC:  prox_misc_reg  <= wb_dat_i[7:0] & `OCADC_MSK_PROX_MISC;
          `OCADC_IDX_AMB_IR_SEL: amb_ir_sel_reg <= wb_dat_i[7:0];
          `OCADC_IDX_AUX_SEL:    aux_sel_reg    <= wb_dat_i[7:0];
          `OCADC_IDX_VIS_REC:    vis_rec_reg    <= wb_dat_i[7:0] & `OCADC_MSK_VIS_REC;
          `OCADC_IDX_VIS_GAIN:   vis_gain_reg   <= wb_dat_i[7:0] & `OCADC_MSK_GAIN;
          `OCADC_IDX_CONTROL: begin
            chan_reg  <= start_chan;
            early_reg <= wb_dat_i[`OCADC_CTL_EARLY_BIT];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Sequencer; every setting is latched at start so writes never disturb a run
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg        <= ST_IDLE;
      run_chan_reg     <= `OCADC_CHAN_PROX;
      run_exp_reg      <= 3'h0;
      run_normal_reg   <= 1'b1;
      count_reg        <= 9'h000;
      adc_input_sel    <= `OCADC_SEL_SMALL_IR;
      adc_ref_gnd      <= 1'b0;
      adc_high_range   <= 1'b0;
      adc_raw_mode     <= 1'b0;
      conv_active      <= 1'b0;
      infrared_emitter <= 1'b0;
      conv_done        <= 1'b0;
      done_reg         <= 1'b0;
      result_reg       <= {DATA_W{1'b0}};
    end else if (ce) begin
      conv_done <= 1'b0;
      if (done_clear) begin
        done_reg <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            run_chan_reg   <= start_chan;
            run_exp_reg    <= start_exp;
            run_normal_reg <= prox_misc_reg[`OCADC_MODE_BIT];
            adc_ref_gnd    <= (start_chan == `OCADC_CHAN_AUX);
            adc_high_range <= (start_chan == `OCADC_CHAN_PROX)
                              & prox_misc_reg[`OCADC_RANGE_BIT];
            adc_raw_mode   <= (start_chan == `OCADC_CHAN_PROX)
                              & ~prox_misc_reg[`OCADC_MODE_BIT];
            adc_input_sel  <= start_sel;
            if (start_rec != 9'h000) begin
              state_reg <= ST_REC;
              count_reg <= start_rec;
            end else begin
              state_reg   <= ST_INTEG;
              count_reg   <= INTEG_CLKS[8:0];
              conv_active <= 1'b1;
              infrared_emitter <= (start_chan == `OCADC_CHAN_PROX)
                                  & prox_misc_reg[`OCADC_MODE_BIT];
            end
          end
        end
        ST_REC: begin
          if (tick) begin
            count_reg <= count_reg - 9'h001;
          end
          if (last_tick) begin
            state_reg   <= ST_INTEG;
            count_reg   <= INTEG_CLKS[8:0];
            conv_active <= 1'b1;
            infrared_emitter <= (run_chan_reg == `OCADC_CHAN_PROX) & run_normal_reg;
          end
        end
        ST_INTEG: begin
          // Both lengths count divided ticks, so both stretch by the gain
          if (tick) begin
            count_reg <= count_reg - 9'h001;
            if (count_reg == INTEG_CLKS[8:0] - EMIT_CLKS[8:0] + 9'h001) begin
              infrared_emitter <= 1'b0;
            end
          end
          if (last_tick) begin
            state_reg        <= ST_IDLE;
            conv_active      <= 1'b0;
            infrared_emitter <= 1'b0;
            result_reg       <= stable_reg;
            conv_done        <= 1'b1;
            done_reg         <= 1'b1;
          end
        end
        default: begin
          state_reg        <= ST_IDLE;
          conv_active      <= 1'b0;
          infrared_emitter <= 1'b0;
        end
      endcase
    end
  end
endmodule // ocadc_channel

// ### tb/ocadc_analog_model.sv
`timescale 1ns/100ps
module ocadc_analog_model #(
  parameter DATA_W = 16
) (
  input  wire logic [7:0]        adc_input_sel,  // Selected converter input
  input  wire logic              adc_high_range, // Reduced gain request
  output logic      [DATA_W-1:0] adc_data_in     // Sample towards the block
);
  // Each input gives its own level, so a wrong selection shows in the result
  assign adc_data_in = {adc_input_sel, adc_input_sel ^ 8'ha5} >> (adc_high_range ? 4 : 0);
endmodule // ocadc_analog_model

// ### tb/ocadc_chk_asserts.sv
`timescale 1ns/100ps
module ocadc_chk #(
  parameter DATA_W = 16
) (
  input wire logic              clk_sys,          // Clock
  input wire logic              rst,              // Reset
  input wire logic              ce,               // Enable
  input wire logic              wb_cyc_i,         // Cycle
  input wire logic              wb_stb_i,         // Strobe
  input wire logic              wb_we_i,          // Write
  input wire logic [7:0]        wb_adr_i,         // Address
  input wire logic [3:0]        wb_sel_i,         // Selects
  input wire logic [31:0]       wb_dat_i,         // Write data
  input wire logic [31:0]       wb_dat_o,         // Read data
  input wire logic              wb_ack_o,         // Ack
  input wire logic [DATA_W-1:0] adc_data_in,      // Sample
  input wire logic [7:0]        adc_input_sel,    // Input select
  input wire logic              adc_ref_gnd,      // Ground reference
  input wire logic              adc_high_range,   // High range
  input wire logic              adc_raw_mode,     // Raw mode
  input wire logic              conv_active,      // Integrating
  input wire logic              infrared_emitter, // Emitter
  input wire logic              conv_done         // Done pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_pulse: assert property (wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_unused: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("unused read bits set");
  a_raw_dark: assert property (adc_raw_mode |-> !infrared_emitter)
    else $error("emitter on in raw mode");
  a_emit_start: assert property ($rose(infrared_emitter) |-> $rose(conv_active) && !adc_raw_mode)
    else $error("emitter rose outside a run start");
  a_emit_inside: assert property (infrared_emitter |-> conv_active)
    else $error("emitter on outside integration");
  a_cfg_hold: assert property (conv_active && $past(conv_active) |-> $stable(adc_input_sel) && $stable(adc_high_range) && $stable(adc_raw_mode))
    else $error("setting changed mid run");
  a_ref_aux: assert property (adc_ref_gnd |-> !adc_high_range && !adc_raw_mode && !infrared_emitter)
    else $error("ground reference outside aux run");
  a_done_pulse: assert property (conv_done && ce |=> !conv_done)
    else $error("done longer than one cycle");
endmodule // ocadc_chk

bind ocadc_channel ocadc_chk #(.DATA_W(DATA_W)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adc_data_in(adc_data_in),
  .adc_input_sel(adc_input_sel), .adc_ref_gnd(adc_ref_gnd), .adc_high_range(adc_high_range),
  .adc_raw_mode(adc_raw_mode), .conv_active(conv_active),
  .infrared_emitter(infrared_emitter), .conv_done(conv_done)
);

// ### tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        clk_sys, rst, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i, adc_input_sel;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] adc_data_in;
  logic        adc_ref_gnd, adc_high_range, adc_raw_mode, conv_active, infrared_emitter;
  logic        conv_done;
  int          n_errors, cmp_count, nc, ne;

  ocadc_channel i_dut (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adc_data_in(adc_data_in),
    .adc_input_sel(adc_input_sel), .adc_ref_gnd(adc_ref_gnd), .adc_high_range(adc_high_range),
    .adc_raw_mode(adc_raw_mode), .conv_active(conv_active),
    .infrared_emitter(infrared_emitter), .conv_done(conv_done)
  );
  ocadc_analog_model i_adc (
    .adc_input_sel(adc_input_sel), .adc_high_range(adc_high_range), .adc_data_in(adc_data_in)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // Run lengths allow eight system clocks of divider phase slack either way
  task automatic near(input int got, input int exp, input string m);
    cmp_count++;
    if (got < exp - 8 || got > exp + 8) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s took %0d expected %0d", $time, m, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int t;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h00_0000, d};
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk(t < 50, 1, "bus answer");
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, {24'h00_0000, e}, "read");
  endtask

  task automatic wt();
    nc = 0;
    ne = 0;
    while (conv_done !== 1'b1 && nc < 20000) begin
      @(posedge clk_sys);
      nc++;
      ne += int'(infrared_emitter === 1'b1);
    end
  endtask

  task automatic conv(input logic [7:0] ctl);
    wb(1'b1, 8'h80, ctl);
    wt();
  endtask

  function automatic logic [31:0] smp(input logic [7:0] s, input logic hr);
    return {16'h0000, s, s ^ 8'ha5} >> (hr ? 4 : 0);
  endfunction

  task automatic t_regs();
    rd(8'h2c, 8'h00);
    rd(8'h30, 8'h04);
    rd(8'h38, 8'h00);
    rd(8'h3c, 8'h65);
    rd(8'h40, 8'h70);
    wb(1'b1, 8'h2c, 8'hff);
    rd(8'h2c, 8'h07);
    wb(1'b1, 8'h30, 8'hff);
    rd(8'h30, 8'h24);
    wb(1'b1, 8'h40, 8'hff);
    rd(8'h40, 8'h70);
    wb(1'b1, 8'hfc, 8'hff);
    rd(8'hfc, 8'h00);
    wb(1'b1, 8'h2c, 8'h00);
    wb(1'b1, 8'h30, 8'h04);
    $display("test regs finished");
  endtask

  task automatic t_gain();
    int g[3] = '{0, 4, 5};
    foreach (g[i]) begin
      wb(1'b1, 8'h2c, 8'(g[i]));
      conv(8'h01);
      near(nc, 80 << g[i], "prox run");
      near(ne, 40 << g[i], "emitter pulse");
      chk({adc_high_range, adc_raw_mode}, 2'b00, "prox mode");
      wb(1'b0, 8'h88, 8'h00);
      chk(q, smp(8'h03, 1'b0), "prox result");
    end
    rd(8'h84, 8'h02);
    wb(1'b1, 8'h84, 8'h02);
    rd(8'h84, 8'h00);
    wb(1'b1, 8'h2c, 8'h00);
    $display("test gain finished");
  endtask

  task automatic t_mode();
    wb(1'b1, 8'h30, 8'h24);
    conv(8'h01);
    wb(1'b0, 8'h88, 8'h00);
    chk(q, smp(8'h03, 1'b1), "high range result");
    wb(1'b1, 8'h30, 8'h20);
    conv(8'h01);
    chk(adc_raw_mode, 1'b1, "raw mode");
    chk(ne, 0, "raw emitter");
    wb(1'b1, 8'h30, 8'h04);
    $display("test mode finished");
  endtask

  task automatic t_sel();
    logic [7:0] s[4] = '{8'h00, 8'h03, 8'h65, 8'h75};
    foreach (s[i]) begin
      wb(1'b1, (i < 2) ? 8'h38 : 8'h3c, s[i]);
      conv((i < 2) ? 8'h05 : 8'h07);
      chk({adc_ref_gnd, adc_input_sel}, {i > 1, s[i]}, "input select");
      if (i < 2) near(nc, 80, "ir run");
      wb(1'b0, 8'h88, 8'h00);
      chk(q, smp(s[i], 1'b0), "select result");
    end
    wb(1'b1, 8'h40, 8'h10);
    wb(1'b1, 8'h44, 8'h01);
    conv(8'h0d);
    near(nc, 230, "early ir run");
    wb(1'b1, 8'h44, 8'h00);
    $display("test select finished");
  endtask

  task automatic t_vis();
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, 8'h40, 8'(c << 4));
      conv(8'h03);
      near(nc, 5 * (((c == 0) ? 1 : (4 << c) - 1) + 16), "visible run");
    end
    wb(1'b1, 8'h40, 8'h00);
    wb(1'b1, 8'h44, 8'h02);
    conv(8'h03);
    near(nc, 340, "visible gain run");
    wb(1'b1, 8'h44, 8'h00);
    wb(1'b1, 8'h40, 8'h70);
    $display("test visible finished");
  endtask

  // Writes land while a run is busy and must wait for the next start
  task automatic t_hold();
    wb(1'b1, 8'h3c, 8'h65);
    wb(1'b1, 8'h80, 8'h07);
    wb(1'b1, 8'h3c, 8'h75);
    wt();
    chk(adc_input_sel, 8'h65, "held select");
    wb(1'b1, 8'h80, 8'h01);
    wb(1'b1, 8'h2c, 8'h05);
    wt();
    near(nc, 80, "held gain run");
    conv(8'h07);
    chk(adc_input_sel, 8'h75, "next select");
    wb(1'b1, 8'h2c, 8'h00);
    $display("test hold finished");
  endtask

  // A low enable stalls the run; it resumes where it stopped
  task automatic t_freeze();
    wb(1'b1, 8'h80, 8'h01);
    repeat (10) @(posedge clk_sys);
    ce <= 1'b0;
    repeat (50) @(posedge clk_sys);
    chk({conv_active, infrared_emitter}, 2'b11, "frozen run");
    ce <= 1'b1;
    wt();
    near(nc, 70, "frozen run length");
    $display("test freeze finished");
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    n_errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_gain();
    t_mode();
    t_sel();
    t_vis();
    t_hold();
    t_freeze();
    wrap_up();
  end

  initial begin
    #500_000;
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule // tb_top
